/* File: logic/sspl_link.v */
// start-stop serial parity link transceiver, device end
`include "sspl_defs.vh"
module sspl_link #(
   parameter BIT_CYC = `SSPL_BIT_CYC
) (
   input  wire       clk,
   input  wire       rst_b,
   input  wire       line_in,          // serial_data_line level from pin
   output reg        line_out,
   output reg        line_oe,
   input  wire       busy_in,          // handshake bit 0
   output reg        busy_out,         // handshake bit 1
   input  wire       rx_start_edge_input,
   input  wire       parity_odd,
   input  wire [7:0] tx_data,
   input  wire       tx_start,         // pulse
   input  wire       rx_arm,           // pulse
   input  wire [7:0] edge_mode_select,
   output reg  [7:0] rx_data_reg,
   output reg        rx_done_reg,
   output reg        parity_error_flag,
   output reg        stop_bit_error_flag,
   output reg        overrun_error_reg,
   output reg        parity_bit_store,
   output reg        direction_flag,
   output reg        tx_busy_reg,
   output reg        serial_restart_reg
);

   // one-hot sequencer states
   localparam S_INIT1 = 9'h001;
   localparam S_INIT2 = 9'h002;
   localparam S_INIT3 = 9'h004;
   localparam S_IDLE  = 9'h008;
   localparam S_TXS   = 9'h010;
   localparam S_TXD   = 9'h020;
   localparam S_RXW   = 9'h040;
   localparam S_RXD   = 9'h080;
   localparam S_STOP  = 9'h100;

   // bit-period figures, cut to the timer width on purpose
   localparam [31:0] BIT_CYC_W = BIT_CYC;
   localparam [15:0] BIT_LAST  = BIT_CYC_W[15:0] - 16'h0001;
   localparam [15:0] BIT_HALF  = {1'b0, BIT_CYC_W[15:1]};

   // sequencer, timer and shift state
   reg  [8:0]  state_reg;
   reg  [8:0]  state_next;
   reg  [15:0] tmr_reg;
   reg  [15:0] tmr_next;
   reg  [3:0]  bit_reg;
   reg  [3:0]  bit_next;
   reg  [7:0]  serial_shift_buffer;
   reg  [7:0]  serial_shift_buffer_next;
   reg         bus_release_trigger;
   reg         bus_release_trigger_next;
   reg         armed_reg;
   reg         armed_next;

   // next values of the registered outputs
   reg         line_out_next;
   reg         line_oe_next;
   reg         busy_out_next;
   reg  [7:0]  rx_data_next;
   reg         rx_done_next;
   reg         parity_error_flag_next;
   reg         stop_bit_error_flag_next;
   reg         overrun_error_next;
   reg         parity_bit_store_next;
   reg         direction_flag_next;
   reg         tx_busy_next;
   reg         serial_restart_next;

   // pin synchronisers; the third edge stage only keeps the previous level
   reg         rx_s1;
   reg         rx_s2;
   reg         rx_s3;
   reg         ln_s1;
   reg         ln_s2;
   reg         bz_s1;
   reg         bz_s2;

   // decoded conditions
   wire        tick;
   wire        edge_ok;
   wire        fall;
   wire        rx_par;

   // odd parity seeds the xor with 1 so data plus parity has odd weight
   function par;
      input [7:0] d;
      input       odd;
      begin
         par = ^d ^ odd;
      end
   endfunction

   // bit timer enable pulse, one clock wide; a mode other than zero masks edges
   assign tick    = (tmr_reg == BIT_LAST);
   assign edge_ok = (edge_mode_select == `SSPL_EDGE_MODE);
   assign fall    = rx_s3 & ~rx_s2 & edge_ok;
   assign rx_par  = par(serial_shift_buffer, parity_odd);

   // two flip-flops per pin before any logic reads it
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         rx_s3 <= 1'b1;
         ln_s1 <= 1'b1;
         ln_s2 <= 1'b1;
         bz_s1 <= 1'b0;
         bz_s2 <= 1'b0;
      end else begin
         rx_s1 <= rx_start_edge_input;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         ln_s1 <= line_in;
         ln_s2 <= ln_s1;
         bz_s1 <= busy_in;
         bz_s2 <= bz_s1;
      end
   end

   // next-state logic; every register except the running timer and the restart pulse holds unless a branch says otherwise
   always @* begin
      state_next               = state_reg;
      tmr_next                 = tick ? 16'h0000 : tmr_reg + 16'h0001;
      bit_next                 = bit_reg;
      serial_shift_buffer_next = serial_shift_buffer;
      bus_release_trigger_next = bus_release_trigger;
      armed_next               = armed_reg;
      line_out_next            = line_out;
      line_oe_next             = line_oe;
      busy_out_next            = busy_out;
      rx_data_next             = rx_data_reg;
      rx_done_next             = rx_done_reg;
      parity_error_flag_next   = parity_error_flag;
      stop_bit_error_flag_next = stop_bit_error_flag;
      overrun_error_next       = overrun_error_reg;
      parity_bit_store_next    = parity_bit_store;
      direction_flag_next      = direction_flag;
      tx_busy_next             = tx_busy_reg;
      serial_restart_next      = 1'b0;

      // arming comes first so an error seen in the same cycle still wins
      if (rx_arm) begin
         direction_flag_next      = 1'b0;
         busy_out_next            = ~busy_out;
         armed_next               = ~busy_out;
         parity_error_flag_next   = 1'b0;
         stop_bit_error_flag_next = 1'b0;
      end

      case (state_reg)
         // pin set-up: latch high, release trigger, then latch cleared
         S_INIT1: begin
            line_out_next = 1'b1;
            line_oe_next  = 1'b1;
            state_next    = S_INIT2;
         end
         S_INIT2: begin
            bus_release_trigger_next = 1'b1;
            state_next               = S_INIT3;
         end
         // the pin is let go while its latch is low, so the line shows no dip
         S_INIT3: begin
            if (bus_release_trigger) begin
               line_out_next            = 1'b0;
               line_oe_next             = 1'b0;
               bus_release_trigger_next = 1'b0;
               state_next               = S_IDLE;
            end
         end
         // idle: the line is held high, a send is taken only while the far end's busy is high
         S_IDLE: begin
            line_out_next = 1'b1;
            line_oe_next  = 1'b1;
            if (tx_start && bz_s2) begin
               direction_flag_next      = 1'b1;
               tx_busy_next             = 1'b1;
               serial_shift_buffer_next = tx_data;
               parity_bit_store_next    = par(tx_data, parity_odd);
               line_out_next            = 1'b0;
               tmr_next                 = 16'h0000;
               state_next               = S_TXS;
            end else if (armed_reg && fall) begin
               line_oe_next = 1'b0;
               tmr_next     = 16'h0000;
               state_next   = S_RXW;
            end
         end
         // start bit stands one full period, then the first data bit
         S_TXS: begin
            if (tick) begin
               line_out_next            = serial_shift_buffer[0];
               serial_shift_buffer_next = {1'b0, serial_shift_buffer[7:1]};
               bit_next                 = 4'h1;
               state_next               = S_TXD;
            end
         end
         // seven more data bits, parity in the ninth slot, then first stop
         S_TXD: begin
            if (tick) begin
               if (bit_reg < 4'h8) begin
                  line_out_next            = serial_shift_buffer[0];
                  serial_shift_buffer_next = {1'b0, serial_shift_buffer[7:1]};
                  bit_next                 = bit_reg + 4'h1;
               end else if (bit_reg == 4'h8) begin
                  line_out_next = parity_bit_store;
                  bit_next      = 4'h9;
               end else begin
                  line_out_next = 1'b1;
                  bit_next      = 4'h0;
                  state_next    = S_STOP;
               end
            end
         end
         // mid-start test rejects glitches; the pin goes back to output after
         S_RXW: begin
            if (tmr_reg == BIT_HALF) begin
               line_oe_next = 1'b1;
               if (!ln_s2) begin
                  serial_shift_buffer_next = 8'hFF;
                  bit_next                 = 4'h0;
                  tmr_next                 = 16'h0000;
                  state_next               = S_RXD;
               end else begin
                  state_next = S_IDLE;
               end
            end
         end
         // timer restarted at mid-start, so each tick falls in a bit's middle
         S_RXD: begin
            if (tick) begin
               if (bit_reg < 4'h8) begin
                  serial_shift_buffer_next = {ln_s2, serial_shift_buffer[7:1]};
               end else begin
                  parity_bit_store_next = ln_s2;
                  state_next            = S_STOP;
               end
               bit_next = bit_reg + 4'h1;
            end
         end
         // two stop periods in either direction, then the serial restart
         S_STOP: begin
            if (tick) begin
               if (direction_flag) begin
                  line_out_next = 1'b1;
               end else if (!ln_s2) begin
                  stop_bit_error_flag_next = 1'b1;
               end
               if (bit_reg == 4'h0 && direction_flag) begin
                  bit_next = 4'h1;
               end else if (bit_reg == 4'h9 && !direction_flag) begin
                  bit_next = 4'hA;
               end else begin
                  // a parity of 1 hides the normal end, so always restart
                  serial_restart_next = 1'b1;
                  tx_busy_next        = 1'b0;
                  line_oe_next        = 1'b1;
                  if (!direction_flag) begin
                     if (rx_done_reg) begin
                        overrun_error_next = 1'b1;
                     end
                     rx_data_next = serial_shift_buffer;
                     if (rx_par != parity_bit_store) begin
                        parity_error_flag_next = 1'b1;
                     end else if (ln_s2 && !stop_bit_error_flag) begin
                        rx_done_next = 1'b1;
                     end
                  end
                  state_next = S_INIT1;
               end
            end
         end
         default: begin
            state_next = S_INIT1;
         end
      endcase
   end

   // state and output registers; outputs come straight from these flops
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg           <= S_INIT1;
         tmr_reg             <= 16'h0000;
         bit_reg             <= 4'h0;
         serial_shift_buffer <= 8'h00;
         bus_release_trigger <= 1'b0;
         armed_reg           <= 1'b0;
         line_out            <= 1'b1;
         line_oe             <= 1'b1;
         busy_out            <= 1'b0;
         rx_data_reg         <= 8'h00;
         rx_done_reg         <= 1'b0;
         parity_error_flag   <= 1'b0;
         stop_bit_error_flag <= 1'b0;
         overrun_error_reg   <= 1'b0;
         parity_bit_store    <= 1'b0;
         direction_flag      <= 1'b0;
         tx_busy_reg         <= 1'b0;
         serial_restart_reg  <= 1'b0;
      end else begin
         state_reg           <= state_next;
         tmr_reg             <= tmr_next;
         bit_reg             <= bit_next;
         serial_shift_buffer <= serial_shift_buffer_next;
         bus_release_trigger <= bus_release_trigger_next;
         armed_reg           <= armed_next;
         line_out            <= line_out_next;
         line_oe             <= line_oe_next;
         busy_out            <= busy_out_next;
         rx_data_reg         <= rx_data_next;
         rx_done_reg         <= rx_done_next;
         parity_error_flag   <= parity_error_flag_next;
         stop_bit_error_flag <= stop_bit_error_flag_next;
         overrun_error_reg   <= overrun_error_next;
         parity_bit_store    <= parity_bit_store_next;
         direction_flag      <= direction_flag_next;
         tx_busy_reg         <= tx_busy_next;
         serial_restart_reg  <= serial_restart_next;
      end
   end

   // note: done and overrun stay set until reset; only the parity and stop-bit error flags clear on arm
   // note: a send and a receive start in the same idle cycle: the send is taken
   // and start edges are ignored until the link is back in idle
endmodule // sspl_link

/* File: logic/sspl_defs.vh */
// constants of the start-stop serial parity link
// How it works
// - serial traffic only while the busy handshake level is 1
// - handshake bit 0 is busy input from receiver, bit 1 our busy output
// - start bit: latch drives line low for one bit-timer period
// - after start shift nine bits: eight data then parity in acknowledge slot
// - stop bits driven high by setting the latch on bit-timer ticks
// - after second stop bit, serial operation is switched off then on
// - parity 1 blocks normal end detection, so the restart is mandatory
// - reception starts on falling rx edge input confirmed by line test
// - start check: pin to input, sample, load shift buffer, pin to output
// - receiver shifts in eight data bits, parity from acknowledge slot
// - each stop-bit tick samples the line, low sets stop-bit error
// - parity select set means odd parity, clear means even, both directions
// - parity mismatch or overrun raises an error flag
// - completion flag set when a received character ends with good parity and stop bits, byte kept for user
// - bit timer gives 9600 bps, compare 54 on 1.05 MHz count clock; the timer here counts 25 MHz / 9600 clocks per bit instead
// - init order: latch 1, release trigger 1, then latch 0
// - receive start: direction flag 0, busy output inverted, then arm edge
// - edge detection falling only, mode register all zeros
`ifndef SSPL_DEFS_VH
`define SSPL_DEFS_VH
`define SSPL_CLK_HZ        25000000
`define SSPL_BAUD          9600
`define SSPL_CNT_CLK_HZ    1050000
`define SSPL_CMP_VAL       54
// cycles per bit: 25 MHz / 9600, rounded down
`define SSPL_BIT_CYC       (`SSPL_CLK_HZ / `SSPL_BAUD)
`define SSPL_EDGE_MODE     8'h00
`define SSPL_DATA_BITS     8
`define SSPL_STOP_BITS     2
`endif

/* File: testbench/sspl_link_assertions.sv */
// concurrent checks on the serial link top ports
module sspl_link_assertions (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic line_out,
   input wire logic line_oe,
   input wire logic busy_out,
   input wire logic rx_arm,
   input wire logic tx_busy_reg,
   input wire logic serial_restart_reg,
   input wire logic direction_flag,
   input wire logic rx_done_reg,
   input wire logic parity_error_flag,
   input wire logic stop_bit_error_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_start_low_hold: assert property (
      $fell(line_out) && tx_busy_reg |-> !line_out [*8])
      else $error("start bit cut short");
   a_stop_then_restart: assert property (
      $rose(serial_restart_reg) |-> $past(line_out | ~line_oe, 2))
      else $error("restart without high stop bit");
   a_restart_one_pulse: assert property (
      serial_restart_reg |=> !serial_restart_reg)
      else $error("restart pulse too long");
   a_arm_busy_toggle: assert property (
      rx_arm |=> busy_out != $past(busy_out))
      else $error("busy output not inverted");
   a_arm_dir_clear: assert property (
      $rose(busy_out) |-> ##[0:1] !direction_flag)
      else $error("direction not cleared on arm");
   a_arm_err_clear: assert property (
      $rose(busy_out) |-> ##[0:1] !(parity_error_flag | stop_bit_error_flag))
      else $error("error flags kept on arm");
   a_done_clean_frame: assert property (
      $rose(rx_done_reg) |-> !parity_error_flag && !stop_bit_error_flag)
      else $error("done set on bad frame");
   a_tx_drives_line: assert property (
      tx_busy_reg |-> line_oe)
      else $error("line not driven in transmit");
endmodule // sspl_link_assertions
bind sspl_link sspl_link_assertions sspl_link_assertions_i (.clk(clk), .rst_b(rst_b),
   .line_out(line_out), .line_oe(line_oe), .busy_out(busy_out), .rx_arm(rx_arm),
   .tx_busy_reg(tx_busy_reg), .serial_restart_reg(serial_restart_reg),
   .direction_flag(direction_flag), .rx_done_reg(rx_done_reg),
   .parity_error_flag(parity_error_flag), .stop_bit_error_flag(stop_bit_error_flag));

/* File: testbench/sspl_peer.sv */
// far-end serial node: busy handshake, frame sender and frame sampler
module sspl_peer #(parameter int BIT = 16) (
   input  wire logic clk,
   input  wire logic line,
   output logic      busy,
   output logic      drv_low
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      busy = 1'b1;
      drv_low = 1'b0;
   end
   // pulls the line low for zeros, releases it to the pull-up for ones
   task automatic send(input logic [7:0] d, input logic par, input logic stop);
      logic [11:0] f;
      f = {stop, stop, par, d, 1'b0};
      for (int i = 0; i < 12; i++) begin
         drv_low = !f[i];
         repeat (BIT) @(negedge clk);
      end
      drv_low = 1'b0;
   endtask
   // waits for the start edge, then samples each bit in its middle
   task automatic grab(output logic [11:0] f, output logic ok);
      ok = 1'b0;
      for (int n = 0; n < 200 && !ok; n++) begin
         @(negedge clk);
         ok = !line;
      end
      repeat (BIT / 2) @(negedge clk);
      for (int i = 0; i < 12; i++) begin
         f[i] = line;
         repeat (BIT) @(negedge clk);
      end
   endtask
endmodule // sspl_peer

/* File: testbench/sspl_link_test.sv */
// self-checking bench for the start-stop serial parity link
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t value mismatch", $time); end end
module sspl_link_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rst_b = 0, tx_start = 0, rx_arm = 0, parity_odd = 0;
   logic [7:0]  tx_data = 8'h00, rxd, edge_mode = 8'h00;
   logic        busy_in, line_out, line_oe, busy_out, drv_low, done, perr, serr, ovr;
   logic        dirf, txb, pbs, ok, q, restart;
   logic [11:0] f;
   logic [31:0] seed = 32'h17;
   int          bad_count = 0, checked = 0, restarts = 0;
   // wired line with pull-up: low wins from either end
   wire         line = (~line_oe | line_out) & ~drv_low;
   always #20 clk = ~clk;
   sspl_link #(.BIT_CYC(16)) sspl_link_i (.clk(clk), .rst_b(rst_b), .line_in(line),
      .line_out(line_out), .line_oe(line_oe), .busy_in(busy_in), .busy_out(busy_out),
      .rx_start_edge_input(line), .parity_odd(parity_odd), .tx_data(tx_data),
      .tx_start(tx_start), .rx_arm(rx_arm), .edge_mode_select(edge_mode), .rx_data_reg(rxd),
      .rx_done_reg(done), .parity_error_flag(perr), .stop_bit_error_flag(serr),
      .overrun_error_reg(ovr), .parity_bit_store(pbs), .direction_flag(dirf),
      .tx_busy_reg(txb), .serial_restart_reg(restart));
   sspl_peer #(.BIT(16)) sspl_peer_i (.clk(clk), .line(line), .busy(busy_in), .drv_low(drv_low));
   // restart pulses counted mid-cycle, where the one-clock pulse has settled
   always @(negedge clk) if (restart === 1'b1) restarts++;
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic par_of(input logic [7:0] d, input logic odd);
      return odd ^ (^d);
   endfunction
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
      // transmit corner bytes then random ones, both parity senses
      for (int i = 0; i < 6; i++) begin
         tx_data = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd();
         parity_odd = i[0];
         pulse(tx_start);
         sspl_peer_i.grab(f, ok);
         `CHK(ok, 1'b1)
         `CHK(f, {2'b11, par_of(tx_data, i[0]), tx_data, 1'b0})
         for (int n = 0; n < 100 && txb !== 1'b0; n++) @(negedge clk);
         `CHK(txb, 1'b0)
         repeat (4) @(negedge clk);
      end
      `CHK(restarts, 6)
      // a send while the far end's busy is low must leave the line idle
      sspl_peer_i.busy = 1'b0;
      repeat (4) @(negedge clk);
      pulse(tx_start);
      q = 1'b0;
      repeat (40) begin
         @(negedge clk);
         q = q | txb | ~line;
      end
      `CHK(q, 1'b0)
      sspl_peer_i.busy = 1'b1;
      // receive: clean, bad parity, bad stop, then clean again; overrun is raised by the second frame
      for (int k = 0; k < 4; k++) begin
         tx_data = rnd();
         parity_odd = k[0];
         if (busy_out === 1'b1) pulse(rx_arm);
         pulse(rx_arm);
         repeat (3) @(negedge clk);
         `CHK({perr, serr, dirf, busy_out}, 4'b0001)
         sspl_peer_i.send(tx_data, par_of(tx_data, k[0]) ^ (k == 1), k != 2);
         repeat (16) @(negedge clk);
         `CHK({perr, serr}, {k == 1, k == 2})
         `CHK(pbs, par_of(tx_data, k[0]) ^ (k == 1))
         if (k == 0 || k == 3) `CHK(rxd, tx_data)
         `CHK(done, 1'b1)
      end
      // edge detection masked by a non-zero mode: a frame must pass unseen
      edge_mode = 8'h01;
      sspl_peer_i.send(~tx_data, 1'b0, 1'b1);
      repeat (16) @(negedge clk);
      `CHK(rxd, tx_data)
      edge_mode = 8'h00;
      `CHK(restarts, 10)
      `CHK(ovr, 1'b1)
      end_sim();
   end
endmodule // sspl_link_test
